// *** design/rbp_bit_addr.sv ***
`timescale 1ns/100ps

//Contract
// - Pre-modify long form adds constant to pointer first, keeps the sum.
// - Long constant comes from the two-byte extension; never in parallel.
// - Short form zero-extends 1..7 offset to 23 bits; pointer unchanged.
// - Extended coefficient pointer is seven high bits over sixteen low bits.
// - Plain coefficient form addresses high:low plus optional base; no update.
// - Post-increment uses current pointer, then adds 1 or 2.
// - Post-decrement uses current pointer, then subtracts 1 or 2.
// - Pair test copies lower bit to first flag, upper to second.
// - Clear or set touches only the addressed accumulator bit.
// - Long constant is signed and sign-extended to 23 bits.
module rbp_bit_addr
   import rbp_pkg::*;
#(
   parameter int unsigned AUX_N = RBP_AUX_N,
   parameter int unsigned ACC_W = RBP_ACC_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [RBP_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // Software-visible state; each register has a next-value twin filled by one process below.
   logic [22:0] aux_r [AUX_N];
   logic [22:0] aux_nxt [AUX_N];
   logic [15:0] coeff_pointer_low_r, coeff_pointer_low_nxt;
   logic [6:0] coeff_pointer_high_r, coeff_pointer_high_nxt;
   logic [15:0] aux_circular_base_r, aux_circular_base_nxt;
   logic [15:0] coeff_circular_base_r, coeff_circular_base_nxt;
   logic [15:0] long_offset_const_r, long_offset_const_nxt;
   logic [8:0] circ_en_r, circ_en_nxt;
   logic [ACC_W-1:0] accumulator_two_r, accumulator_two_nxt;
   logic [ACC_W-1:0] accumulator_three_r, accumulator_three_nxt;
   logic [22:0] last_addr_r, last_addr_nxt;
   rbp_status_t status_reg_zero_r, status_reg_zero_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;

   // Decode of the command on the bus, recomputed every cycle from the write data.
   rbp_cmd_t cmd;
   logic [22:0] ext_coeff_pointer;
   logic [22:0] ext_aux_pointer;
   logic [22:0] long_sext;
   logic [22:0] aux_pre;
   logic [22:0] bit_addr;
   logic cmd_legal;
   logic setup;
   logic wr_commit;
   logic is_aux_page;
   logic [2:0] aux_idx;
   logic mapped;

   // Bit address from a 23-bit pointer and offset; in circular mode the
   // base and offset act on the low part only, which wraps in 16 bits.
   // Linear mode lets a carry reach the high part; circular mode never does.
   function automatic logic [22:0] form_addr(input logic [22:0] ptr, input logic [22:0] ofs,
                                             input logic circ, input logic [15:0] base);
      logic [15:0] low;
      low = 16'(base + ptr[15:0] + ofs[15:0]);
      if (circ) begin
         form_addr = {ptr[22:16], low};
      end else begin
         form_addr = 23'(ptr + ofs);
      end
   endfunction

   // The command fields are only meaningful while a command write is on the bus;
   // elsewhere they are decoded anyway and simply ignored.
   assign setup = psel & ~penable;
   assign wr_commit = psel & penable & pready_r & pwrite & ~pslverr_r;
   assign is_aux_page = (paddr[7:5] == RBP_AUX_PAGE);
   assign aux_idx = paddr[4:2];
   assign cmd = rbp_cmd_t'(pwdata[RBP_CMD_W-1:0]);
   assign ext_coeff_pointer = {coeff_pointer_high_r, coeff_pointer_low_r};
   assign ext_aux_pointer = aux_r[cmd.aux_sel];
   // Sign extension lets a negative long constant step the pointer backwards.
   assign long_sext = {{7{long_offset_const_r[15]}}, long_offset_const_r};
   assign aux_pre = 23'(ext_aux_pointer + long_sext);

   // Address generation per operand form.
   always_comb begin
      bit_addr = ext_coeff_pointer;
      case (cmd.form)
         RBP_FORM_AUX_PRE_LONG: begin
            bit_addr = form_addr(aux_pre, RBP_PTR_RST, circ_en_r[cmd.aux_sel], aux_circular_base_r);
         end
         RBP_FORM_AUX_SHORT: begin
            bit_addr = form_addr(ext_aux_pointer, {20'h00000, cmd.short_offset_const},
                                 circ_en_r[cmd.aux_sel], aux_circular_base_r);
         end
         RBP_FORM_COEFF, RBP_FORM_COEFF_INC, RBP_FORM_COEFF_DEC: begin
            bit_addr = form_addr(ext_coeff_pointer, RBP_PTR_RST, circ_en_r[RBP_CIRC_COEFF_BIT],
                                 coeff_circular_base_r);
         end
         default: begin
            bit_addr = ext_coeff_pointer;
         end
      endcase
   end

   // A command is refused if its form is reserved, the short offset is zero,
   // the operation code is unused, or a long-offset form is issued in parallel.
   // Refusal is judged from the setup-cycle data, which the master holds into the access phase.
   always_comb begin
      cmd_legal = 1'b1;
      if (cmd.form > RBP_FORM_COEFF_DEC || cmd.op == RBP_OP_NONE) begin
         cmd_legal = 1'b0;
      end
      if (cmd.form == RBP_FORM_AUX_SHORT && cmd.short_offset_const == 3'h0) begin
         cmd_legal = 1'b0;
      end
      if (cmd.form == RBP_FORM_AUX_PRE_LONG && cmd.parallel) begin
         cmd_legal = 1'b0;
      end
   end

   // Address decode for the current request.
   always_comb begin
      mapped = 1'b1;
      if (is_aux_page) begin
         mapped = (32'(aux_idx) < AUX_N);
      end else begin
         case (paddr)
            RBP_CMD_OFS, RBP_LONG_OFS, RBP_STATUS_OFS, RBP_LAST_ADDR_OFS, RBP_COEFF_LOW_OFS,
            RBP_COEFF_HIGH_OFS, RBP_AUX_BASE_OFS, RBP_COEFF_BASE_OFS, RBP_CIRC_EN_OFS,
            RBP_ACC_TWO_OFS, RBP_ACC_THREE_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   end

   // Bus answer: decided in the setup cycle, presented one edge later so the
   // access phase completes at its first edge and all outputs come from flops.
   // Registering the answer keeps the read mux off the bus timing path at no extra cycle.
   always_comb begin
      pready_nxt = setup;
      pslverr_nxt = 1'b0;
      prdata_nxt = 32'h00000000;
      if (setup) begin
         pslverr_nxt = ~mapped | (pwrite & (paddr == RBP_CMD_OFS) & ~cmd_legal);
         if (!pwrite && is_aux_page && mapped) begin
            prdata_nxt = {9'h000, aux_r[aux_idx]};
         end else if (!pwrite) begin
            case (paddr)
               RBP_LONG_OFS: prdata_nxt = {16'h0000, long_offset_const_r};
               RBP_STATUS_OFS: prdata_nxt = {28'h0000000, status_reg_zero_r};
               RBP_LAST_ADDR_OFS: prdata_nxt = {9'h000, last_addr_r};
               RBP_COEFF_LOW_OFS: prdata_nxt = {16'h0000, coeff_pointer_low_r};
               RBP_COEFF_HIGH_OFS: prdata_nxt = {25'h0000000, coeff_pointer_high_r};
               RBP_AUX_BASE_OFS: prdata_nxt = {16'h0000, aux_circular_base_r};
               RBP_COEFF_BASE_OFS: prdata_nxt = {16'h0000, coeff_circular_base_r};
               RBP_CIRC_EN_OFS: prdata_nxt = {23'h000000, circ_en_r};
               RBP_ACC_TWO_OFS: prdata_nxt = 32'(accumulator_two_r);
               RBP_ACC_THREE_OFS: prdata_nxt = 32'(accumulator_three_r);
               default: prdata_nxt = 32'h00000000;
            endcase
         end
      end
   end

   // Register writes and command execution. A command executes only at the
   // completing edge of its write, so one bus transfer is one instruction.
   always_comb begin
      logic [ACC_W-1:0] acc;
      logic [22:0] step;
      logic in_range;
      acc = cmd.acc_sel ? accumulator_three_r : accumulator_two_r;
      step = (cmd.op == RBP_OP_PAIR_TEST) ? RBP_STEP_TWO : RBP_STEP_ONE;
      in_range = (cmd.op == RBP_OP_PAIR_TEST) ? (32'(bit_addr) + 32'd1 < ACC_W) : (32'(bit_addr) < ACC_W);
      for (int i = 0; i < AUX_N; i++) begin
         aux_nxt[i] = aux_r[i];
      end
      coeff_pointer_low_nxt = coeff_pointer_low_r;
      coeff_pointer_high_nxt = coeff_pointer_high_r;
      aux_circular_base_nxt = aux_circular_base_r;
      coeff_circular_base_nxt = coeff_circular_base_r;
      long_offset_const_nxt = long_offset_const_r;
      circ_en_nxt = circ_en_r;
      accumulator_two_nxt = accumulator_two_r;
      accumulator_three_nxt = accumulator_three_r;
      last_addr_nxt = last_addr_r;
      status_reg_zero_nxt = status_reg_zero_r;
      // Write-one-to-clear on the sticky error bits; a new event below wins.
      // Only the low byte lane is honoured, since every status bit lives there.
      if (wr_commit && paddr == RBP_STATUS_OFS && pstrb[0]) begin
         status_reg_zero_nxt.refused = status_reg_zero_r.refused & ~pwdata[RBP_ST_REFUSED_BIT];
         status_reg_zero_nxt.range_err = status_reg_zero_r.range_err & ~pwdata[RBP_ST_RANGE_BIT];
      end
      // A refused command leaves a sticky mark; this set sits after the clear so it wins.
      if (psel && penable && pready_r && pwrite && pslverr_r && paddr == RBP_CMD_OFS) begin
         status_reg_zero_nxt.refused = 1'b1;
      end
      if (wr_commit && is_aux_page) begin
         aux_nxt[aux_idx] = pwdata[22:0];
      end
      if (wr_commit && !is_aux_page) begin
         case (paddr)
            RBP_LONG_OFS: long_offset_const_nxt = pwdata[15:0];
            RBP_COEFF_LOW_OFS: coeff_pointer_low_nxt = pwdata[15:0];
            RBP_COEFF_HIGH_OFS: coeff_pointer_high_nxt = pwdata[6:0];
            RBP_AUX_BASE_OFS: aux_circular_base_nxt = pwdata[15:0];
            RBP_COEFF_BASE_OFS: coeff_circular_base_nxt = pwdata[15:0];
            RBP_CIRC_EN_OFS: circ_en_nxt = pwdata[8:0];
            RBP_ACC_TWO_OFS: accumulator_two_nxt = pwdata[ACC_W-1:0];
            RBP_ACC_THREE_OFS: accumulator_three_nxt = pwdata[ACC_W-1:0];
            RBP_CMD_OFS: begin
               last_addr_nxt = bit_addr;
               // Pointer updates; plain and short forms leave pointers alone.
               // Post steps wrap modulo 2^23, so the top of the space rolls back to zero.
               case (cmd.form)
                  RBP_FORM_AUX_PRE_LONG: aux_nxt[cmd.aux_sel] = aux_pre;
                  RBP_FORM_COEFF_INC: begin
                     {coeff_pointer_high_nxt, coeff_pointer_low_nxt} = 23'(ext_coeff_pointer + step);
                  end
                  RBP_FORM_COEFF_DEC: begin
                     {coeff_pointer_high_nxt, coeff_pointer_low_nxt} = 23'(ext_coeff_pointer - step);
                  end
                  default: last_addr_nxt = bit_addr;
               endcase
               // A bit beyond the accumulator is flagged; the accumulator and test flags keep their values.
               // Pointer updates above still apply, so a sweep past the top keeps its place.
               if (!in_range) begin
                  status_reg_zero_nxt.range_err = 1'b1;
               end else begin
                  case (cmd.op)
                     RBP_OP_CLEAR: acc[bit_addr[4:0]] = 1'b0;
                     RBP_OP_SET: acc[bit_addr[4:0]] = 1'b1;
                     RBP_OP_PAIR_TEST: begin
                        status_reg_zero_nxt.test_flag_first = acc[bit_addr[4:0]];
                        status_reg_zero_nxt.test_flag_second = acc[5'(bit_addr[4:0] + 5'h01)];
                     end
                     default: acc = acc;
                  endcase
                  if (cmd.acc_sel) begin
                     accumulator_three_nxt = acc;
                  end else begin
                     accumulator_two_nxt = acc;
                  end
               end
            end
            default: last_addr_nxt = last_addr_r;
         endcase
      end
   end

   // State registers; all take constants under reset.
   // The pointer array resets in a loop so AUX_N may change without edits here.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < AUX_N; i++) begin
            aux_r[i] <= RBP_PTR_RST;
         end
         coeff_pointer_low_r <= RBP_WORD_RST;
         coeff_pointer_high_r <= RBP_PTR_RST[22:16];
         aux_circular_base_r <= RBP_WORD_RST;
         coeff_circular_base_r <= RBP_WORD_RST;
         long_offset_const_r <= RBP_WORD_RST;
         circ_en_r <= RBP_CIRC_RST;
         accumulator_two_r <= RBP_ACC_RST[ACC_W-1:0];
         accumulator_three_r <= RBP_ACC_RST[ACC_W-1:0];
         last_addr_r <= RBP_PTR_RST;
         status_reg_zero_r <= '0;
         prdata_r <= 32'h00000000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         for (int i = 0; i < AUX_N; i++) begin
            aux_r[i] <= aux_nxt[i];
         end
         coeff_pointer_low_r <= coeff_pointer_low_nxt;
         coeff_pointer_high_r <= coeff_pointer_high_nxt;
         aux_circular_base_r <= aux_circular_base_nxt;
         coeff_circular_base_r <= coeff_circular_base_nxt;
         long_offset_const_r <= long_offset_const_nxt;
         circ_en_r <= circ_en_nxt;
         accumulator_two_r <= accumulator_two_nxt;
         accumulator_three_r <= accumulator_three_nxt;
         last_addr_r <= last_addr_nxt;
         status_reg_zero_r <= status_reg_zero_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // Outputs come straight from flops; no logic sits between them and the pins.
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

endmodule // rbp_bit_addr

// *** design/rbp_pkg.sv ***
package rbp_pkg;

   // Address and data widths of the register-bit pointer unit.
   localparam int unsigned RBP_PTR_W = 23;
   localparam int unsigned RBP_LOW_W = 16;
   localparam int unsigned RBP_HIGH_W = 7;
   localparam int unsigned RBP_AUX_N = 8;
   localparam int unsigned RBP_ACC_W = 32;
   localparam int unsigned RBP_CMD_W = 13;
   localparam int unsigned RBP_ADDR_W = 8;

   // Register byte offsets on the APB.
   localparam logic [7:0] RBP_CMD_OFS = 8'h00;
   localparam logic [7:0] RBP_LONG_OFS = 8'h04;
   localparam logic [7:0] RBP_STATUS_OFS = 8'h08;
   localparam logic [7:0] RBP_LAST_ADDR_OFS = 8'h0c;
   localparam logic [7:0] RBP_COEFF_LOW_OFS = 8'h10;
   localparam logic [7:0] RBP_COEFF_HIGH_OFS = 8'h14;
   localparam logic [7:0] RBP_AUX_BASE_OFS = 8'h18;
   localparam logic [7:0] RBP_COEFF_BASE_OFS = 8'h1c;
   localparam logic [7:0] RBP_CIRC_EN_OFS = 8'h20;
   localparam logic [7:0] RBP_ACC_TWO_OFS = 8'h24;
   localparam logic [7:0] RBP_ACC_THREE_OFS = 8'h28;
   localparam logic [7:0] RBP_AUX_OFS = 8'h40;
   localparam logic [2:0] RBP_AUX_PAGE = 3'h2;

   // Status register bit positions, and the coefficient bit of the circular-enable register.
   localparam int unsigned RBP_ST_FLAG1_BIT = 0;
   localparam int unsigned RBP_ST_FLAG2_BIT = 1;
   localparam int unsigned RBP_ST_REFUSED_BIT = 2;
   localparam int unsigned RBP_ST_RANGE_BIT = 3;
   localparam int unsigned RBP_CIRC_COEFF_BIT = 8;

   // Values after reset.
   localparam logic [22:0] RBP_PTR_RST = 23'h000000;
   localparam logic [15:0] RBP_WORD_RST = 16'h0000;
   localparam logic [31:0] RBP_ACC_RST = 32'h00000000;
   localparam logic [8:0] RBP_CIRC_RST = 9'h000;

   // Pointer steps for post-modified coefficient forms.
   localparam logic [22:0] RBP_STEP_ONE = 23'h000001;
   localparam logic [22:0] RBP_STEP_TWO = 23'h000002;

   typedef enum logic [1:0] {
      RBP_OP_CLEAR,
      RBP_OP_SET,
      RBP_OP_PAIR_TEST,
      RBP_OP_NONE
   } rbp_op_t;

   typedef enum logic [2:0] {
      RBP_FORM_AUX_PRE_LONG,
      RBP_FORM_AUX_SHORT,
      RBP_FORM_COEFF,
      RBP_FORM_COEFF_INC,
      RBP_FORM_COEFF_DEC,
      RBP_FORM_RSV5,
      RBP_FORM_RSV6,
      RBP_FORM_RSV7
   } rbp_form_t;

   // Command word as written to the command register, low 13 bits.
   typedef struct packed {
      logic parallel;
      logic acc_sel;
      logic [2:0] short_offset_const;
      logic [2:0] aux_sel;
      rbp_form_t form;
      rbp_op_t op;
   } rbp_cmd_t;

   // Sticky and result flags of the status register.
   typedef struct packed {
      logic range_err;
      logic refused;
      logic test_flag_second;
      logic test_flag_first;
   } rbp_status_t;

endpackage

// *** verification/rbp_bit_addr_assertions.sv ***
`timescale 1ns/100ps

// Watches only the register bus pins of the bit-address unit.
module rbp_bit_addr_assertions
   import rbp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [RBP_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // A write to the command register seen in its setup cycle.
   logic cmd_setup;
   assign cmd_setup = psel && !penable && pwrite && (paddr == RBP_CMD_OFS);

   a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("pready late");
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
   a_ready_in_access: assert property (pready |-> psel && penable) else $error("pready outside access");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
   a_data_idle_zero: assert property (!pready |-> prdata == 32'h00000000) else $error("prdata not idle");
   a_unmapped_err: assert property (psel && !penable && (paddr inside {[8'h2c:8'h3c]} || paddr > 8'h5f)
      |=> pready && pslverr) else $error("unmapped address accepted");
   a_cmd_reads_zero: assert property (psel && !penable && !pwrite && paddr == RBP_CMD_OFS
      |=> prdata == 32'h00000000) else $error("command register readable");
   a_long_parallel: assert property (cmd_setup && pwdata[12] && pwdata[4:2] == 3'h0
      |=> pslverr) else $error("parallel long form accepted");
   a_short_zero: assert property (cmd_setup && pwdata[4:2] == 3'h1 && pwdata[10:8] == 3'h0
      |=> pslverr) else $error("zero short offset accepted");
   a_coeff_ok: assert property (cmd_setup && pwdata[4:2] inside {3'h2, 3'h3, 3'h4}
      && pwdata[1:0] != 2'h3 |=> pready && !pslverr) else $error("legal coefficient command refused");

   c_cmd_write: cover property (cmd_setup ##1 pready);
   c_refused: cover property (cmd_setup ##1 pslverr);
   c_read: cover property (psel && !penable && !pwrite ##1 pready);
endmodule // rbp_bit_addr_assertions

bind rbp_bit_addr rbp_bit_addr_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));

// *** verification/rbp_apb_master.sv ***
`timescale 1ns/100ps

// Register bus master standing in for the decoder that issues bit commands.
module rbp_apb_master
   import rbp_pkg::*;
(
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [RBP_ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   int tmo_count = 0;

   // Idle bus from time zero.
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hf;
   end

   // One transfer; the request stands for up to 20 edges until pready is seen high at an edge, so a slow answer is safe.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) tmo_count++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // rbp_apb_master

// *** verification/rbp_bit_addr_tb.sv ***
`timescale 1ns/100ps

module rbp_bit_addr_tb
   import rbp_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [RBP_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   int fail_count = 0;
   int check_count = 0;

   // 25 MHz bus clock.
   always #20 pclk = ~pclk;

   rbp_bit_addr DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   rbp_apb_master m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   task automatic close_out();
      if (fail_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask

   // A hung bus ends the run at once rather than stalling every later scenario.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
      logic [31:0] r;
      logic e;
      m.xfer(1'b1, a, d, r, e);
      if (m.tmo_count != 0) begin
         fail_count++;
         close_out();
      end else begin
         chk("pslverr", {31'h0, e}, {31'h0, ee});
      end
   endtask

   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp, input logic ee);
      logic [31:0] r;
      logic e;
      m.xfer(1'b0, a, 32'h0, r, e);
      if (m.tmo_count != 0) begin
         fail_count++;
         close_out();
      end else begin
         chk(n, r, exp);
         chk("pslverr", {31'h0, e}, {31'h0, ee});
      end
   endtask

   function automatic logic [31:0] mk(rbp_op_t op, rbp_form_t f, logic [2:0] s, logic [2:0] k, logic acc,
                                      logic par);
      mk = {19'h0, par, acc, k, s, f, op};
   endfunction

   // Reset values, the write-only command word and an unmapped hole.
   task automatic s_reset();
      rdc("status", RBP_STATUS_OFS, 32'h0, 1'b0);
      rdc("coeff_low", RBP_COEFF_LOW_OFS, 32'h0, 1'b0);
      rdc("aux7", RBP_AUX_OFS + 8'h1c, 32'h0, 1'b0);
      rdc("cmd", RBP_CMD_OFS, 32'h0, 1'b0);
      rdc("hole", 8'h30, 32'h0, 1'b1);
   endtask

   // Short offset pair test, then a refused zero offset.
   task automatic s_short();
      wr(8'h54, 32'h10, 1'b0);
      wr(RBP_ACC_THREE_OFS, 32'h00200000, 1'b0);
      wr(RBP_CMD_OFS, mk(RBP_OP_PAIR_TEST, RBP_FORM_AUX_SHORT, 3'h5, 3'h5, 1'b1, 1'b0), 1'b0);
      rdc("status", RBP_STATUS_OFS, 32'h1, 1'b0);
      rdc("last", RBP_LAST_ADDR_OFS, 32'h15, 1'b0);
      rdc("aux5", 8'h54, 32'h10, 1'b0);
      wr(RBP_CMD_OFS, mk(RBP_OP_SET, RBP_FORM_AUX_SHORT, 3'h5, 3'h0, 1'b1, 1'b0), 1'b1);
      rdc("status", RBP_STATUS_OFS, 32'h5, 1'b0);
   endtask

   // Pre-modify with a negative long constant; the parallel variant is refused first.
   task automatic s_pre_long();
      wr(8'h48, 32'h28, 1'b0);
      wr(RBP_LONG_OFS, 32'h0000ffe5, 1'b0);
      wr(RBP_ACC_TWO_OFS, 32'hffffffff, 1'b0);
      wr(RBP_CMD_OFS, mk(RBP_OP_CLEAR, RBP_FORM_AUX_PRE_LONG, 3'h2, 3'h0, 1'b0, 1'b1), 1'b1);
      rdc("aux2", 8'h48, 32'h28, 1'b0);
      wr(RBP_CMD_OFS, mk(RBP_OP_CLEAR, RBP_FORM_AUX_PRE_LONG, 3'h2, 3'h0, 1'b0, 1'b0), 1'b0);
      rdc("aux2", 8'h48, 32'h0d, 1'b0);
      rdc("last", RBP_LAST_ADDR_OFS, 32'h0d, 1'b0);
      rdc("acc_two", RBP_ACC_TWO_OFS, 32'hffffdfff, 1'b0);
   endtask

   // Coefficient pointer: plain, post-increment and post-decrement with both step sizes.
   task automatic s_coeff();
      wr(RBP_COEFF_LOW_OFS, 32'h1e, 1'b0);
      wr(RBP_ACC_THREE_OFS, 32'h80000000, 1'b0);
      wr(RBP_CMD_OFS, mk(RBP_OP_PAIR_TEST, RBP_FORM_COEFF, 3'h0, 3'h0, 1'b1, 1'b0), 1'b0);
      rdc("status", RBP_STATUS_OFS, 32'h6, 1'b0);
      rdc("coeff_low", RBP_COEFF_LOW_OFS, 32'h1e, 1'b0);
      wr(RBP_CMD_OFS, mk(RBP_OP_SET, RBP_FORM_COEFF_INC, 3'h0, 3'h0, 1'b1, 1'b0), 1'b0);
      rdc("coeff_low", RBP_COEFF_LOW_OFS, 32'h1f, 1'b0);
      rdc("acc_three", RBP_ACC_THREE_OFS, 32'hc0000000, 1'b0);
      wr(RBP_CMD_OFS, mk(RBP_OP_CLEAR, RBP_FORM_COEFF_DEC, 3'h0, 3'h0, 1'b1, 1'b0), 1'b0);
      rdc("acc_three", RBP_ACC_THREE_OFS, 32'h40000000, 1'b0);
      wr(RBP_CMD_OFS, mk(RBP_OP_PAIR_TEST, RBP_FORM_COEFF_DEC, 3'h0, 3'h0, 1'b1, 1'b0), 1'b0);
      rdc("status", RBP_STATUS_OFS, 32'h5, 1'b0);
      rdc("coeff_low", RBP_COEFF_LOW_OFS, 32'h1c, 1'b0);
      wr(RBP_CMD_OFS, mk(RBP_OP_PAIR_TEST, RBP_FORM_COEFF_INC, 3'h0, 3'h0, 1'b1, 1'b0), 1'b0);
      rdc("coeff_low", RBP_COEFF_LOW_OFS, 32'h1e, 1'b0);
   endtask

   // Carry from the low part into the high part, then circular base off and on.
   task automatic s_ext_circ();
      wr(RBP_COEFF_HIGH_OFS, 32'h01, 1'b0);
      wr(RBP_COEFF_LOW_OFS, 32'hffff, 1'b0);
      wr(RBP_CMD_OFS, mk(RBP_OP_CLEAR, RBP_FORM_COEFF_INC, 3'h0, 3'h0, 1'b1, 1'b0), 1'b0);
      rdc("coeff_high", RBP_COEFF_HIGH_OFS, 32'h02, 1'b0);
      rdc("coeff_low", RBP_COEFF_LOW_OFS, 32'h0, 1'b0);
      rdc("last", RBP_LAST_ADDR_OFS, 32'h1ffff, 1'b0);
      wr(RBP_COEFF_HIGH_OFS, 32'h0, 1'b0);
      wr(RBP_COEFF_LOW_OFS, 32'h4, 1'b0);
      wr(RBP_COEFF_BASE_OFS, 32'h10, 1'b0);
      wr(RBP_CMD_OFS, mk(RBP_OP_SET, RBP_FORM_COEFF, 3'h0, 3'h0, 1'b1, 1'b0), 1'b0);
      rdc("last", RBP_LAST_ADDR_OFS, 32'h4, 1'b0);
      wr(RBP_CIRC_EN_OFS, 32'h100, 1'b0);
      wr(RBP_CMD_OFS, mk(RBP_OP_SET, RBP_FORM_COEFF, 3'h0, 3'h0, 1'b1, 1'b0), 1'b0);
      rdc("last", RBP_LAST_ADDR_OFS, 32'h14, 1'b0);
      rdc("acc_three", RBP_ACC_THREE_OFS, 32'h40100010, 1'b0);
   endtask

   // Sticky error bits clear one at a time; then an address from an aux pointer wraps in circular mode.
   task automatic s_flags();
      rdc("status", RBP_STATUS_OFS, 32'hc, 1'b0);
      wr(RBP_STATUS_OFS, 32'h4, 1'b0);
      rdc("status", RBP_STATUS_OFS, 32'h8, 1'b0);
      wr(RBP_STATUS_OFS, 32'h8, 1'b0);
      rdc("status", RBP_STATUS_OFS, 32'h0, 1'b0);
      wr(RBP_AUX_OFS + 8'h0c, 32'hffff, 1'b0);
      wr(RBP_AUX_BASE_OFS, 32'h5, 1'b0);
      wr(RBP_CIRC_EN_OFS, 32'h008, 1'b0);
      wr(RBP_ACC_TWO_OFS, 32'h0, 1'b0);
      wr(RBP_CMD_OFS, mk(RBP_OP_SET, RBP_FORM_AUX_SHORT, 3'h3, 3'h2, 1'b0, 1'b0), 1'b0);
      rdc("last", RBP_LAST_ADDR_OFS, 32'h6, 1'b0);
      rdc("acc_two", RBP_ACC_TWO_OFS, 32'h40, 1'b0);
      rdc("aux3", RBP_AUX_OFS + 8'h0c, 32'hffff, 1'b0);
   endtask

   // Main sequence: reset held for eight cycles, then every scenario in turn.
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      s_reset();
      s_short();
      s_pre_long();
      s_coeff();
      s_ext_circ();
      s_flags();
      close_out();
   end
endmodule // rbp_bit_addr_tb
